// ---- design/sbl_pkg.sv ----
// Constants shared by the serial boot load and erase command handler
package sbl_pkg;

  // Command and code bytes
  localparam logic [7:0] CMD_RAM_LOAD   = 8'h10;
  localparam logic [7:0] CMD_ERASE      = 8'h40;
  localparam logic [7:0] CODE_ERASE_EN  = 8'h54;
  localparam logic [7:0] CODE_ERASE_OK  = 8'h4f;
  localparam logic [7:0] CODE_ERASE_BAD = 8'h4c;

  // Acknowledge low nibbles; bits 1 and 2 always zero
  localparam logic [3:0] ACK_RX_ERR     = 4'h8;
  localparam logic [3:0] ACK_BAD        = 4'h1;

  // Header: four address bytes, two length bytes, one checksum
  localparam logic [15:0] HDR_LAST      = 16'h0006;

  // Destination window
  localparam logic [31:0] RAM_LOW_ADDR  = 32'h2000_0400;
  localparam logic [31:0] RAM_END_DFLT  = 32'h2000_ffff;

  // Values after reset
  localparam logic [3:0]  NIB_RST       = 4'h0;
  localparam logic [7:0]  BYTE_RST      = 8'h00;
  localparam logic [15:0] CNT_RST       = 16'h0000;
  localparam logic [31:0] ADDR_RST      = 32'h0000_0000;
  localparam logic [47:0] HDR_RST       = 48'h0000_0000_0000;

  typedef enum logic [3:0]
  {
    ST_CMD   = 4'h0,
    ST_SEND  = 4'h1,
    ST_PW    = 4'h2,
    ST_HDR   = 4'h3,
    ST_PAY   = 4'h4,
    ST_PCK   = 4'h5,
    ST_JUMP  = 4'h6,
    ST_EN    = 4'h7,
    ST_ERASE = 4'h8,
    ST_EWAIT = 4'h9
  } sbl_state_e;

endpackage

// ---- design/sbl_rx_stage.sv ----
// Received byte stage with per-byte receive error latch
`timescale 1ns/1ns
module sbl_rx_stage
(
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  // From the serial receiver
  input  wire logic       rx_valid_in,
  input  wire logic [7:0] rx_data_in,
  input  wire logic       frame_err_in,
  input  wire logic       parity_err_in,
  input  wire logic       overrun_err_in,
  // To the command handler
  output logic            byte_valid_out,
  output logic [7:0]      byte_data_out,
  output logic            byte_err_out
);

  logic       valid_d;
  logic       valid_q;
  logic [7:0] data_d;
  logic [7:0] data_q;
  logic       err_d;
  logic       err_q;

  always_comb
  begin
    valid_d = rx_valid_in;
    data_d  = data_q;
    err_d   = err_q;
    if (rx_valid_in)
    begin
      data_d = rx_data_in;
      // Error travels with its own byte only
      err_d  = frame_err_in | parity_err_in | overrun_err_in; // RQ22
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      valid_q <= 1'b0;
      data_q  <= sbl_pkg::BYTE_RST;
      err_q   <= 1'b0;
    end
    else
    begin
      valid_q <= valid_d;
      data_q  <= data_d;
      err_q   <= err_d;
    end
  end

  assign byte_valid_out = valid_q;
  assign byte_data_out  = data_q;
  assign byte_err_out   = err_q;

endmodule

// ---- design/sbl_cksum.sv ----
// Modulo-256 byte sum accumulator
`timescale 1ns/1ns
module sbl_cksum
(
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  // Control and data
  input  wire logic       clear_in,
  input  wire logic       add_in,
  input  wire logic [7:0] byte_in,
  // Running sum and sum including byte_in
  output logic [7:0]      sum_out,
  output logic [7:0]      sum_with_out
);

  logic [7:0] sum_d;
  logic [7:0] sum_q;

  always_comb
  begin
    // Carry dropped by the 8-bit target
    sum_with_out = 8'(sum_q + byte_in);
    sum_d        = sum_q;
    if (clear_in)
      sum_d = sbl_pkg::BYTE_RST;
    else if (add_in)
      sum_d = sum_with_out;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      sum_q <= sbl_pkg::BYTE_RST;
    else
      sum_q <= sum_d;
  end

  assign sum_out = sum_q;

endmodule

// ---- design/sbl_boot_cmd.sv ----
// Serial boot command handler: RAM load header, payload, jump and erase
// Function
// RQ1: Controller gives an even RAM start address.
// RQ2: Two length bytes follow the address, high byte first.
// RQ3: Controller sends header checksum as two's complement of byte sum.
// RQ4: Any header receive error answers 0x18 and returns to command wait.
// RQ5: In clocked interface mode receive errors are ignored entirely.
// RQ6: Nonzero modulo-256 header sum answers 0x11 and returns to command wait.
// RQ7: Destination region must lie from 0x2000_0400 to the RAM end.
// RQ8: Passing header checks answers 0x10.
// RQ9: Payload stored at successive addresses from start for length bytes.
// RQ10: Controller sends payload checksum as two's complement of payload sum.
// RQ11: Payload answer 0x18 on receive error, 0x11 on bad sum, else 0x10.
// RQ12: Jump to the start address only after normal payload answer is sent.
// RQ13: Erase command byte 0x40 handled like the load command byte.
// RQ14: Command byte receive error answers previous nibble with bit 3 set.
// RQ15: Known command echoed; unknown answers previous nibble with bit 0 set.
// RQ16: Controller sends erase enable code 0x54 after the echo.
// RQ17: Valid enable code is echoed, then the chip erase starts.
// RQ18: Invalid enable code answers bit 0 set and returns to command wait.
// RQ19: Answers carry command nibble, bit 3 receive error, bit 0 other errors.
// RQ20: Erase end sends 0x4F on success, 0x4C on error.
// RQ21: Load command is byte 0x10 and its normal answer is 0x10.
// RQ22: Receiver keeps a receive error flag for every byte.
// RQ23: Handler keeps the last accepted command upper nibble.
`timescale 1ns/1ns
module sbl_boot_cmd
#(
  parameter logic [31:0] RAM_END_ADDR = sbl_pkg::RAM_END_DFLT
)
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // Serial receiver bytes
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        frame_err_in,
  input  wire logic        parity_err_in,
  input  wire logic        overrun_err_in,
  input  wire logic        sync_mode_in,
  // Serial transmitter bytes
  output logic             tx_valid_out,
  output logic [7:0]       tx_data_out,
  input  wire logic        tx_ready_in,
  // Password stage result
  input  wire logic        pw_done_in,
  input  wire logic        pw_ok_in,
  // RAM write port
  output logic             ram_we_out,
  output logic [31:0]      ram_addr_out,
  output logic [7:0]       ram_data_out,
  // Branch to loaded code
  output logic             jump_out,
  output logic [31:0]      jump_addr_out,
  // Chip erase engine
  output logic             erase_start_out,
  input  wire logic        erase_done_in,
  input  wire logic        erase_err_in
);

  sbl_pkg::sbl_state_e st_d, st_q;
  sbl_pkg::sbl_state_e ret_d, ret_q;

  logic        tx_valid_d, tx_valid_q;
  logic [7:0]  tx_data_d, tx_data_q;
  logic [3:0]  nib_d, nib_q;
  logic [15:0] cnt_d, cnt_q;
  logic [47:0] hdr_d, hdr_q;
  logic        gerr_d, gerr_q;
  logic [31:0] ptr_d, ptr_q;
  logic        ram_we_d, ram_we_q;
  logic [31:0] ram_addr_d, ram_addr_q;
  logic [7:0]  ram_data_d, ram_data_q;
  logic        jump_d, jump_q;
  logic        erase_d, erase_q;
  logic        b_valid, b_err_raw, b_err, ck_clr, ck_add, range_ok;
  logic [7:0]  b_data, ck_sum_with;
  logic [31:0] hdr_addr;
  logic [15:0] hdr_len;
  logic [32:0] hdr_end;

  sbl_rx_stage u_rx
  (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .rx_valid_in(rx_valid_in),
    .rx_data_in(rx_data_in), .frame_err_in(frame_err_in),
    .parity_err_in(parity_err_in), .overrun_err_in(overrun_err_in),
    .byte_valid_out(b_valid), .byte_data_out(b_data),
    .byte_err_out(b_err_raw)
  );

  sbl_cksum u_ck
  (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .clear_in(ck_clr),
    .add_in(ck_add), .byte_in(b_data), .sum_out(),
    .sum_with_out(ck_sum_with)
  );

  // Clocked interface mode has no usable error flags
  assign b_err = b_err_raw & ~sync_mode_in; // RQ5

  // Address in bytes one to four, length in five and six
  assign hdr_addr = hdr_q[47:16];
  assign hdr_len  = hdr_q[15:0]; // RQ2
  // One past the last byte; 33 bits so a wrap cannot pass the check
  assign hdr_end  = {1'b0, hdr_addr} + {17'h0_0000, hdr_len};
  assign range_ok = (hdr_addr >= sbl_pkg::RAM_LOW_ADDR) &&
                    (hdr_end <= {1'b0, RAM_END_ADDR} + 33'h0_0000_0001); // RQ7

  always_comb
  begin
    st_d       = st_q;
    ret_d      = ret_q;
    tx_valid_d = tx_valid_q;
    tx_data_d  = tx_data_q;
    nib_d      = nib_q;
    cnt_d      = cnt_q;
    hdr_d      = hdr_q;
    gerr_d     = gerr_q;
    ptr_d      = ptr_q;
    ram_we_d   = 1'b0;
    ram_addr_d = ram_addr_q;
    ram_data_d = ram_data_q;
    jump_d     = 1'b0;
    erase_d    = 1'b0;
    ck_clr     = 1'b0;
    ck_add     = 1'b0;
    case (st_q)
      sbl_pkg::ST_CMD:
      begin
        // Bytes sent while an answer is pending are ignored elsewhere
        if (b_valid)
        begin
          st_d       = sbl_pkg::ST_SEND;
          tx_valid_d = 1'b1;
          ret_d      = sbl_pkg::ST_CMD;
          if (b_err)
            tx_data_d = {nib_q, sbl_pkg::ACK_RX_ERR}; // RQ14
          else if (b_data == sbl_pkg::CMD_RAM_LOAD)
          begin
            tx_data_d = b_data; // RQ21
            nib_d     = b_data[7:4]; // RQ23
            ret_d     = sbl_pkg::ST_PW;
          end
          else if (b_data == sbl_pkg::CMD_ERASE)
          begin
            tx_data_d = b_data; // RQ13
            nib_d     = b_data[7:4]; // RQ23
            ret_d     = sbl_pkg::ST_EN;
          end
          else
            tx_data_d = {nib_q, sbl_pkg::ACK_BAD}; // RQ15
        end
      end
      sbl_pkg::ST_SEND:
      begin
        if (tx_ready_in)
        begin
          tx_valid_d = 1'b0;
          st_d       = ret_q;
        end
      end
      sbl_pkg::ST_PW:
      begin
        // Password stage sends its own answer
        if (pw_done_in)
        begin
          st_d   = pw_ok_in ? sbl_pkg::ST_HDR : sbl_pkg::ST_CMD;
          cnt_d  = sbl_pkg::CNT_RST;
          gerr_d = 1'b0;
          ck_clr = 1'b1;
        end
      end
      sbl_pkg::ST_HDR:
      begin
        if (b_valid)
        begin
          ck_add = 1'b1;
          gerr_d = gerr_q | b_err;
          if (cnt_q == sbl_pkg::HDR_LAST)
          begin
            st_d       = sbl_pkg::ST_SEND;
            tx_valid_d = 1'b1;
            ret_d      = sbl_pkg::ST_CMD;
            cnt_d      = sbl_pkg::CNT_RST;
            gerr_d     = 1'b0;
            ck_clr     = 1'b1;
            ptr_d      = hdr_addr;
            // Receive error outranks checksum and range faults
            if (gerr_q | b_err)
              tx_data_d = {nib_q, sbl_pkg::ACK_RX_ERR}; // RQ4
            else if ((ck_sum_with != sbl_pkg::BYTE_RST) || !range_ok)
              tx_data_d = {nib_q, sbl_pkg::ACK_BAD}; // RQ6
            else
            begin
              tx_data_d = sbl_pkg::CMD_RAM_LOAD; // RQ8
              ret_d     = (hdr_len == sbl_pkg::CNT_RST) ?
                          sbl_pkg::ST_PCK : sbl_pkg::ST_PAY;
            end
          end
          else
          begin
            hdr_d = {hdr_q[39:0], b_data};
            cnt_d = 16'(cnt_q + 16'h0001);
          end
        end
      end
      sbl_pkg::ST_PAY:
      begin
        if (b_valid)
        begin
          ram_we_d   = 1'b1; // RQ9
          ram_addr_d = ptr_q;
          ram_data_d = b_data;
          ptr_d      = 32'(ptr_q + 32'h0000_0001);
          ck_add     = 1'b1;
          gerr_d     = gerr_q | b_err;
          if (cnt_q == 16'(hdr_len - 16'h0001))
            st_d = sbl_pkg::ST_PCK;
          else
            cnt_d = 16'(cnt_q + 16'h0001);
        end
      end
      sbl_pkg::ST_PCK:
      begin
        if (b_valid)
        begin
          st_d       = sbl_pkg::ST_SEND;
          tx_valid_d = 1'b1;
          ret_d      = sbl_pkg::ST_CMD;
          gerr_d     = 1'b0;
          ck_clr     = 1'b1;
          if (gerr_q | b_err)
            tx_data_d = {nib_q, sbl_pkg::ACK_RX_ERR}; // RQ11
          else if (ck_sum_with != sbl_pkg::BYTE_RST)
            tx_data_d = {nib_q, sbl_pkg::ACK_BAD}; // RQ11
          else
          begin
            tx_data_d = sbl_pkg::CMD_RAM_LOAD; // RQ11
            ret_d     = sbl_pkg::ST_JUMP;
          end
        end
      end
      sbl_pkg::ST_JUMP:
      begin
        // Reached only once the normal answer has left
        jump_d = 1'b1; // RQ12
        st_d   = sbl_pkg::ST_CMD;
      end
      sbl_pkg::ST_EN:
      begin
        if (b_valid)
        begin
          st_d       = sbl_pkg::ST_SEND;
          tx_valid_d = 1'b1;
          ret_d      = sbl_pkg::ST_CMD;
          if (b_err)
            tx_data_d = {nib_q, sbl_pkg::ACK_RX_ERR}; // RQ19
          else if (b_data != sbl_pkg::CODE_ERASE_EN)
            tx_data_d = {nib_q, sbl_pkg::ACK_BAD}; // RQ18
          else
          begin
            tx_data_d = b_data; // RQ17
            ret_d     = sbl_pkg::ST_ERASE;
          end
        end
      end
      sbl_pkg::ST_ERASE:
      begin
        erase_d = 1'b1; // RQ17
        st_d    = sbl_pkg::ST_EWAIT;
      end
      sbl_pkg::ST_EWAIT:
      begin
        if (erase_done_in)
        begin
          st_d       = sbl_pkg::ST_SEND;
          tx_valid_d = 1'b1;
          ret_d      = sbl_pkg::ST_CMD;
          tx_data_d  = erase_err_in ? sbl_pkg::CODE_ERASE_BAD :
                                      sbl_pkg::CODE_ERASE_OK; // RQ20
        end
      end
      default:
      begin
        st_d       = sbl_pkg::ST_CMD;
        tx_valid_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      st_q       <= sbl_pkg::ST_CMD;
      ret_q      <= sbl_pkg::ST_CMD;
      tx_valid_q <= 1'b0;
      tx_data_q  <= sbl_pkg::BYTE_RST;
      nib_q      <= sbl_pkg::NIB_RST;
      cnt_q      <= sbl_pkg::CNT_RST;
      hdr_q      <= sbl_pkg::HDR_RST;
      gerr_q     <= 1'b0;
      ptr_q      <= sbl_pkg::ADDR_RST;
      ram_we_q   <= 1'b0;
      ram_addr_q <= sbl_pkg::ADDR_RST;
      ram_data_q <= sbl_pkg::BYTE_RST;
      jump_q     <= 1'b0;
      erase_q    <= 1'b0;
    end
    else
    begin
      st_q       <= st_d;
      ret_q      <= ret_d;
      tx_valid_q <= tx_valid_d;
      tx_data_q  <= tx_data_d;
      nib_q      <= nib_d;
      cnt_q      <= cnt_d;
      hdr_q      <= hdr_d;
      gerr_q     <= gerr_d;
      ptr_q      <= ptr_d;
      ram_we_q   <= ram_we_d;
      ram_addr_q <= ram_addr_d;
      ram_data_q <= ram_data_d;
      jump_q     <= jump_d;
      erase_q    <= erase_d;
    end
  end

  assign tx_valid_out    = tx_valid_q;
  assign tx_data_out     = tx_data_q;
  assign ram_we_out      = ram_we_q;
  assign ram_addr_out    = ram_addr_q;
  assign ram_data_out    = ram_data_q;
  assign jump_out        = jump_q;
  assign jump_addr_out   = hdr_addr;
  assign erase_start_out = erase_q;

endmodule

// ---- test/sbl_boot_cmd_sva.sv ----
// Port checker for the serial boot command handler
`timescale 1ns/1ns
module sbl_boot_cmd_sva
(
  // Clock and reset
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  // Receive side
  input wire logic        rx_valid_in,
  input wire logic [7:0]  rx_data_in,
  input wire logic        sync_mode_in,
  // Answers
  input wire logic        tx_valid_out,
  input wire logic [7:0]  tx_data_out,
  input wire logic        tx_ready_in,
  // RAM, branch and erase
  input wire logic        ram_we_out,
  input wire logic [31:0] ram_addr_out,
  input wire logic [7:0]  ram_data_out,
  input wire logic        jump_out,
  input wire logic        erase_start_out,
  input wire logic        erase_done_in,
  input wire logic        erase_err_in
);
  logic [31:0] last_q;
  logic        run_q;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  // Any answer ends a payload run, so loads never chain addresses
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || tx_valid_out)
      run_q <= 1'b0;
    else if (ram_we_out)
      run_q <= 1'b1;
    if (ram_we_out)
      last_q <= ram_addr_out;
  end

  ack_hold_a: assert property (
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
    else $error("answer changed before it was taken");
  ack_drop_a: assert property (
    tx_valid_out && tx_ready_in |=> !tx_valid_out)
    else $error("answer still up after it was taken");
  ack_cause_a: assert property (
    $rose(tx_valid_out) |-> $past(rx_valid_in, 2) || $past(erase_done_in))
    else $error("answer without a received byte");
  sync_noerr_a: assert property (
    tx_valid_out && sync_mode_in |-> tx_data_out[3:0] != 4'h8)
    else $error("receive error answer in clocked mode");
  wr_cause_a: assert property (
    ram_we_out |-> $past(rx_valid_in, 2)
      && ram_data_out == $past(rx_data_in, 2))
    else $error("RAM write not from a received byte");
  wr_step_a: assert property (
    ram_we_out && run_q |-> ram_addr_out == last_q + 32'h1)
    else $error("RAM address not successive");
  jump_after_a: assert property (
    jump_out |-> $past(tx_valid_out && tx_ready_in && tx_data_out == 8'h10, 2)
      || $past(tx_valid_out && tx_ready_in && tx_data_out == 8'h10, 3))
    else $error("branch without a normal answer");
  jump_pulse_a: assert property (jump_out |=> !jump_out)
    else $error("branch pulse too long");
  erase_after_a: assert property (
    erase_start_out |->
      $past(tx_valid_out && tx_ready_in && tx_data_out == 8'h54, 2)
      || $past(tx_valid_out && tx_ready_in && tx_data_out == 8'h54, 3))
    else $error("erase started without enable echo");
  erase_code_a: assert property (
    $past(erase_done_in) |-> tx_valid_out
      && tx_data_out == ($past(erase_err_in) ? 8'h4c : 8'h4f))
    else $error("wrong erase completion code");
  reset_idle_a: assert property (
    $fell(rst_in) |-> !tx_valid_out && !ram_we_out && !jump_out
      && !erase_start_out)
    else $error("outputs active after reset");
endmodule

bind sbl_boot_cmd sbl_boot_cmd_sva u_sva
(
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .rx_valid_in(rx_valid_in),
  .rx_data_in(rx_data_in), .sync_mode_in(sync_mode_in),
  .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
  .tx_ready_in(tx_ready_in), .ram_we_out(ram_we_out),
  .ram_addr_out(ram_addr_out), .ram_data_out(ram_data_out),
  .jump_out(jump_out), .erase_start_out(erase_start_out),
  .erase_done_in(erase_done_in), .erase_err_in(erase_err_in)
);

// ---- test/sbl_ctl_model.sv ----
// Programming controller model: sends bytes, takes answers
`timescale 1ns/1ns
module sbl_ctl_model
(
  // Clock
  input  wire logic       sys_clk_in,
  // Answers from the handler
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            tx_ready_out,
  // Bytes to the handler
  output logic            rx_valid_out,
  output logic [7:0]      rx_data_out,
  output logic            frame_err_out,
  output logic            parity_err_out,
  output logic            overrun_err_out
);
  int lag = 0;

  initial
  begin
    tx_ready_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    {frame_err_out, parity_err_out, overrun_err_out} = 3'h0;
  end

  // Error kind: 1 framing, 2 parity, 3 overrun
  task send_b(input logic [7:0] b, input logic [1:0] e);
    @(negedge sys_clk_in);
    rx_valid_out = 1'b1;
    rx_data_out = b;
    {frame_err_out, parity_err_out, overrun_err_out} =
      {e == 2'h1, e == 2'h2, e == 2'h3};
    @(negedge sys_clk_in);
    rx_valid_out = 1'b0;
    // Released line shows the inverse, not a stale copy
    rx_data_out = ~b;
    {frame_err_out, parity_err_out, overrun_err_out} = 3'h0;
  endtask

  task take_ack(output logic [7:0] d, output logic ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 300 && !ok; n++)
    begin
      @(negedge sys_clk_in);
      ok = (tx_valid_in === 1'b1);
    end
    d = tx_data_in;
    repeat (lag) @(negedge sys_clk_in);
    tx_ready_out = 1'b1;
    @(negedge sys_clk_in);
    tx_ready_out = 1'b0;
  endtask
endmodule

// ---- test/sbl_boot_cmd_tb.sv ----
// Self-checking bench for the serial boot command handler
`timescale 1ns/1ns
module sbl_boot_cmd_tb;
  logic        sys_clk_in, rst_in, rx_valid, frame_err, parity_err;
  logic        overrun_err, sync_mode, tx_valid, tx_ready, pw_done;
  logic        pw_ok, ram_we, jump, erase_start, erase_done, erase_err;
  logic [7:0]  rx_data, tx_data, ram_data;
  logic [31:0] ram_addr, jump_addr, base, ja;
  int          bad_count = 0, checked = 0, wr_n = 0, jump_n = 0;
  int          start_n = 0;

  sbl_boot_cmd dut
  (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .rx_valid_in(rx_valid),
    .rx_data_in(rx_data), .frame_err_in(frame_err),
    .parity_err_in(parity_err), .overrun_err_in(overrun_err),
    .sync_mode_in(sync_mode), .tx_valid_out(tx_valid),
    .tx_data_out(tx_data), .tx_ready_in(tx_ready), .pw_done_in(pw_done),
    .pw_ok_in(pw_ok), .ram_we_out(ram_we), .ram_addr_out(ram_addr),
    .ram_data_out(ram_data), .jump_out(jump), .jump_addr_out(jump_addr),
    .erase_start_out(erase_start), .erase_done_in(erase_done),
    .erase_err_in(erase_err)
  );

  sbl_ctl_model m
  (
    .sys_clk_in(sys_clk_in), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
    .tx_ready_out(tx_ready), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
    .frame_err_out(frame_err), .parity_err_out(parity_err),
    .overrun_err_out(overrun_err)
  );

  initial
  begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Sampled mid-cycle, well away from the launching edge
  always @(negedge sys_clk_in)
  begin
    if (ram_we === 1'b1)
    begin
      chk(ram_addr, base + 32'(wr_n));
      chk(32'(ram_data), 32'(8'h3c + 8'(wr_n * 7)));
      wr_n++;
    end
    if (jump === 1'b1)
    begin
      jump_n++;
      ja = jump_addr;
    end
    if (erase_start === 1'b1)
      start_n++;
  end

  // Send one byte and judge the answer it draws
  task cmd(input logic [7:0] b, input logic [1:0] e, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    m.send_b(b, e);
    m.take_ack(d, ok);
    chk({23'h0, ok, d}, {24'h1, exp});
  endtask

  task t_erase(input logic bad);
    int         s;
    logic [7:0] d;
    logic       ok;
    s = start_n;
    cmd(8'h40, 2'h0, 8'h40);
    cmd(8'h54, 2'h0, 8'h54);
    repeat (4) @(negedge sys_clk_in);
    chk(32'(start_n), 32'(s + 1));
    erase_err = bad;
    erase_done = 1'b1;
    @(negedge sys_clk_in);
    erase_done = 1'b0;
    m.take_ack(d, ok);
    chk({23'h0, ok, d}, bad ? 32'h14c : 32'h14f);
  endtask

  task t_pw_fail;
    cmd(8'h10, 2'h0, 8'h10);
    @(negedge sys_clk_in);
    pw_ok = 1'b0;
    pw_done = 1'b1;
    @(negedge sys_clk_in);
    pw_done = 1'b0;
    cmd(8'h33, 2'h0, 8'h11);
  endtask

  // Reset in erase enable wait after an erase command; nibble must restart at zero
  task t_reset;
    cmd(8'h40, 2'h0, 8'h40);
    rst_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    rst_in = 1'b0;
    cmd(8'h33, 2'h0, 8'h01);
  endtask

  task t_load(input logic [31:0] a, input logic [15:0] n,
              input logic [1:0] he, input logic hs, input logic [7:0] hk,
              input logic [1:0] pe, input logic [7:0] pk);
    logic [7:0] hdr [6];
    logic [7:0] s, b;
    int         i, j0;
    hdr = '{a[31:24], a[23:16], a[15:8], a[7:0], n[15:8], n[7:0]};
    cmd(8'h10, 2'h0, 8'h10);
    @(negedge sys_clk_in);
    pw_ok = 1'b1;
    pw_done = 1'b1;
    @(negedge sys_clk_in);
    pw_done = 1'b0;
    s = 8'h00;
    for (i = 0; i < 6; i++)
    begin
      m.send_b(hdr[i], i == 2 ? he : 2'h0);
      s = s + hdr[i];
    end
    cmd(8'h00 - s + {7'h0, hs}, 2'h0, hk);
    if (hk != 8'h10)
      return;
    base = a;
    wr_n = 0;
    j0 = jump_n;
    s = 8'h00;
    for (i = 0; i < n; i++)
    begin
      b = 8'h3c + 8'(i * 7);
      m.send_b(b, i == 0 ? pe : 2'h0);
      s = s + b;
    end
    cmd(8'h00 - s + {7'h0, pk == 8'h11}, 2'h0, pk);
    repeat (5) @(negedge sys_clk_in);
    chk(32'(jump_n), 32'(j0 + (pk == 8'h10)));
    if (pk == 8'h10)
    begin
      chk(32'(wr_n), 32'(n));
      chk(ja, a);
    end
  endtask

  initial
  begin
    rst_in = 1'b1;
    sync_mode = 1'b0;
    {pw_done, pw_ok, erase_done, erase_err} = 4'h0;
    repeat (20) @(negedge sys_clk_in);
    rst_in = 1'b0;
    t_erase(1'b0);
    m.lag = 3;
    t_erase(1'b1);
    cmd(8'h33, 2'h0, 8'h41);
    cmd(8'h10, 2'h1, 8'h48);
    cmd(8'h40, 2'h0, 8'h40);
    cmd(8'h55, 2'h0, 8'h41);
    cmd(8'h40, 2'h0, 8'h40);
    cmd(8'h54, 2'h2, 8'h48);
    t_load(32'h2000_0400, 16'h5, 2'h0, 1'b0, 8'h10, 2'h0, 8'h10);
    t_load(32'h2000_fff0, 16'h10, 2'h0, 1'b0, 8'h10, 2'h0, 8'h10);
    t_load(32'h2000_fff2, 16'h10, 2'h0, 1'b0, 8'h11, 2'h0, 8'h10);
    t_load(32'h2000_03fe, 16'h2, 2'h0, 1'b0, 8'h11, 2'h0, 8'h10);
    t_load(32'h2000_0800, 16'h0, 2'h0, 1'b0, 8'h10, 2'h0, 8'h10);
    t_load(32'h2000_0800, 16'h4, 2'h0, 1'b1, 8'h11, 2'h0, 8'h10);
    t_load(32'h2000_0800, 16'h4, 2'h3, 1'b0, 8'h18, 2'h0, 8'h10);
    t_load(32'h2000_0800, 16'h4, 2'h0, 1'b0, 8'h10, 2'h1, 8'h18);
    t_load(32'h2000_0800, 16'h4, 2'h0, 1'b0, 8'h10, 2'h0, 8'h11);
    cmd(8'h22, 2'h0, 8'h11);
    t_pw_fail;
    sync_mode = 1'b1;
    t_load(32'h2000_0a00, 16'h3, 2'h2, 1'b0, 8'h10, 2'h3, 8'h10);
    cmd(8'h40, 2'h1, 8'h40);
    cmd(8'h57, 2'h0, 8'h41);
    t_reset;
    wrap_up;
  end

  initial
  begin
    repeat (30000) @(posedge sys_clk_in);
    bad_count++;
    wrap_up;
  end
endmodule
